// ---- src/dlb_defines.vh ----
// Register map, field positions and reset values of the bridge core
`ifndef DLB_DEFINES_VH
`define DLB_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DLB_OFS_SOFT_RESET   8'h09
`define DLB_OFS_STATUS       8'h0A
`define DLB_OFS_PLL_CTRL     8'h0D
`define DLB_OFS_LANE_CFG     8'h10
`define DLB_OFS_LVDS_FMT     8'h18
`define DLB_OFS_ERROR_FLAGS  8'hE5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DLB_BIT_SOFT_RESET   0
`define DLB_BIT_PLL_EN       0
`define DLB_BIT_B_LSB_LANE3  0
`define DLB_BIT_A_LSB_LANE3  1
`define DLB_BIT_A_WIDE       3
`define DLB_BIT_SINGLE_LINK  4
`define DLB_BIT_RUNNING      0
`define DLB_BIT_HS_SEEN      1
`define DLB_ERR_PARTIAL_PIX  0
`define DLB_ERR_NOT_READY    1
`define DLB_ERR_UNPAIRED     2

// ----------------------------------------------------------------
// Reset values and special codes
// ----------------------------------------------------------------
`define DLB_RST_PLL_CTRL     8'h00
`define DLB_RST_LANE_CFG     8'h03
`define DLB_RST_LVDS_FMT     8'h00
`define DLB_RST_ERROR_FLAGS  8'h00
`define DLB_CLEAR_ALL_ERR    8'hFF
`define DLB_BYTES_PER_PIXEL  2'h2

`endif

// ---- src/dlb_lane_merge.v ----
// Merges one byte per active lane into a byte stream, lane 0 first
module dlb_lane_merge #(
  parameter LANES = 4
) (
  // Clock and reset
  input  wire               clk_sys,
  input  wire               reset,
  // Lane word in
  input  wire               word_load,
  input  wire [8*LANES-1:0] word_data,
  input  wire [1:0]         lane_count_m1,
  // Byte stream out
  output reg                byte_valid_reg,
  output reg  [7:0]         byte_data_reg,
  output wire               busy
);

  reg [8*LANES-1:0] word_reg;
  reg [1:0]         idx_reg;
  reg               active_reg;

  assign busy = active_reg;

  // ----------------------------------------------------------------
  // Round-robin walk
  // ----------------------------------------------------------------
  // Lanes are taken as already aligned, so no deskew is attempted
  always @(posedge clk_sys) begin
    if (reset) begin
      word_reg       <= {8*LANES{1'b0}};
      idx_reg        <= 2'h0;
      active_reg     <= 1'b0;
      byte_valid_reg <= 1'b0;
      byte_data_reg  <= 8'h00;
    end else if (word_load) begin
      word_reg       <= word_data;
      idx_reg        <= 2'h1;
      active_reg     <= (lane_count_m1 != 2'h0);
      byte_valid_reg <= 1'b1;
      byte_data_reg  <= word_data[7:0];
    end else if (active_reg) begin
      byte_valid_reg <= 1'b1;
      byte_data_reg  <= word_reg[8*idx_reg +: 8];
      idx_reg        <= idx_reg + 2'h1;
      active_reg     <= (idx_reg != lane_count_m1);
    end else begin
      byte_valid_reg <= 1'b0;
    end
  end

endmodule

// ---- src/dlb_bridge_core.v ----
// DSI lane intake, register file and LVDS pixel formatting of the bridge
// ----------------------------------------------------------------
// Summary of operation
// - Enable low holds everything reset, ignores inputs and releases all outputs.
// - Core stays idle until configured, clock multiplier enabled and soft reset issued.
// - Writing all ones to error flags clears them; read after 1 ms.
// - Dual link sends odd pixels on channel A, even pixels on channel B.
// - With no video flowing, pixel outputs are zero while sync keeps flowing.
// - Format 2 puts the two colour MSBs on the fourth output pair.
// - Format 1 puts the two colour LSBs on the fourth output pair.
// - Channel A Format 1 without wide colour drops LSBs and the fourth pair.
// - Single link holds channel B low; channel A fourth pair is held low at 18 bpp in Format 1 only.
// - Each input takes one to four data lanes, four by default.
// - High-speed lane bytes are merged into a byte stream, lanes taken as aligned.
// ----------------------------------------------------------------
`include "dlb_defines.vh"

module dlb_bridge_core #(
  parameter LANES = 4
) (
  // Clock and reset
  input  wire               clk_sys,
  input  wire               reset,
  // Enable pin
  input  wire               en_pin,
  // DSI link, asynchronous
  input  wire               dsi_byte_clk,
  input  wire               dsi_lane_hs,
  input  wire [8*LANES-1:0] dsi_lane_bytes,
  // Sync state from packet decode, same clock
  input  wire               hsync_in,
  input  wire               vsync_in,
  // Register port
  input  wire               reg_wr,
  input  wire               reg_rd,
  input  wire [7:0]         reg_addr,
  input  wire [7:0]         reg_wdata,
  output reg  [7:0]         reg_rdata_reg,
  output reg                reg_rvalid_reg,
  // LVDS channel A
  output reg  [17:0]        a_pairs_reg,
  output reg  [5:0]         a_fourth_output_pair_reg,
  output reg                a_clk_run_reg,
  // LVDS channel B
  output reg  [17:0]        b_pairs_reg,
  output reg  [5:0]         b_fourth_output_pair_reg,
  output reg                b_clk_run_reg,
  // Sync and framing
  output reg                hsync_out_reg,
  output reg                vsync_out_reg,
  output reg                de_out_reg,
  output reg                pix_strobe_reg,
  output wire               out_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg               en_s1_reg, en_s2_reg;
  reg               bclk_s1_reg, bclk_s2_reg, bclk_s3_reg;
  reg               hs_s1_reg, hs_s2_reg;
  reg [8*LANES-1:0] dat_s1_reg, dat_s2_reg;
  reg [7:0]         pll_ctrl_reg, lane_cfg_reg, lvds_fmt_reg, err_reg;
  reg               running_reg, hs_seen_reg;
  reg [1:0]         byte_cnt_reg;
  reg [15:0]        pix_part_reg;
  reg               pair_half_reg;
  reg [23:0]        pix_a_reg;
  reg               hs_d_reg;
  reg [7:0]         err_next;
  reg [7:0]         rd_next;
  wire              shut;
  wire              bclk_fall;
  wire              word_load;
  wire              m_valid;
  wire [7:0]        m_byte;
  wire              m_busy;
  wire              single_link;
  wire              pix_done;
  wire [23:0]       pix_new;
  wire              burst_end;
  wire              wr_ok;
  wire [23:0]       fa_new, fa_held, fb_new;

  // ----------------------------------------------------------------
  // Pixel layout onto the four pairs
  // ----------------------------------------------------------------
  function [23:0] dlb_fmt;
    input [23:0] pix;
    input        lsb_on_fourth;
    input        wide;
    begin
      if (lsb_on_fourth) begin
        dlb_fmt[17:0]  = {pix[23:18], pix[15:10], pix[7:2]};
        dlb_fmt[23:18] = wide ? {pix[17:16], pix[9:8], pix[1:0]} : 6'h00;
      end else begin
        dlb_fmt[17:0]  = {pix[21:16], pix[13:8], pix[5:0]};
        dlb_fmt[23:18] = {pix[23:22], pix[15:14], pix[7:6]};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Enable pin and link synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
    end else begin
      en_s1_reg <= en_pin;
      en_s2_reg <= en_s1_reg;
    end
  end

  assign shut   = reset | ~en_s2_reg;
  assign out_oe = en_s2_reg;

  // Data is caught on the falling byte-clock edge, mid-way between changes
  always @(posedge clk_sys) begin
    if (shut) begin
      bclk_s1_reg <= 1'b0;
      bclk_s2_reg <= 1'b0;
      bclk_s3_reg <= 1'b0;
      hs_s1_reg   <= 1'b0;
      hs_s2_reg   <= 1'b0;
      dat_s1_reg  <= {8*LANES{1'b0}};
      dat_s2_reg  <= {8*LANES{1'b0}};
    end else begin
      bclk_s1_reg <= dsi_byte_clk;
      bclk_s2_reg <= bclk_s1_reg;
      bclk_s3_reg <= bclk_s2_reg;
      hs_s1_reg   <= dsi_lane_hs;
      hs_s2_reg   <= hs_s1_reg;
      dat_s1_reg  <= dsi_lane_bytes;
      dat_s2_reg  <= dat_s1_reg;
    end
  end

  assign bclk_fall = bclk_s3_reg & ~bclk_s2_reg;
  assign word_load = bclk_fall & hs_s2_reg & running_reg;

  // ----------------------------------------------------------------
  // Lane merge
  // ----------------------------------------------------------------
  dlb_lane_merge #(
    .LANES         (LANES)
  ) u_merge (
    .clk_sys       (clk_sys),
    .reset         (shut),
    .word_load     (word_load),
    .word_data     (dat_s2_reg),
    .lane_count_m1 (lane_cfg_reg[1:0]),
    .byte_valid_reg(m_valid),
    .byte_data_reg (m_byte),
    .busy          (m_busy)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  assign wr_ok     = reg_wr & ~shut;
  assign burst_end = hs_d_reg & ~hs_s2_reg;
  assign pix_done  = m_valid & (byte_cnt_reg == `DLB_BYTES_PER_PIXEL);
  assign pix_new   = {pix_part_reg, m_byte};

  always @* begin
    err_next = err_reg;
    if (wr_ok && reg_addr == `DLB_OFS_ERROR_FLAGS) begin
      err_next = err_reg & ~reg_wdata;
    end
    // Hardware events win over a clear in the same cycle
    if (burst_end && byte_cnt_reg != 2'h0) begin
      err_next[`DLB_ERR_PARTIAL_PIX] = 1'b1;
    end
    if (bclk_fall && hs_s2_reg && !running_reg) begin
      err_next[`DLB_ERR_NOT_READY] = 1'b1;
    end
    if (burst_end && pair_half_reg) begin
      err_next[`DLB_ERR_UNPAIRED] = 1'b1;
    end
  end

  always @* begin
    case (reg_addr)
      `DLB_OFS_STATUS:      rd_next = {6'h00, hs_seen_reg, running_reg};
      `DLB_OFS_PLL_CTRL:    rd_next = pll_ctrl_reg;
      `DLB_OFS_LANE_CFG:    rd_next = lane_cfg_reg;
      `DLB_OFS_LVDS_FMT:    rd_next = lvds_fmt_reg;
      `DLB_OFS_ERROR_FLAGS: rd_next = err_reg;
      default:              rd_next = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (shut) begin
      pll_ctrl_reg   <= `DLB_RST_PLL_CTRL;
      lane_cfg_reg   <= `DLB_RST_LANE_CFG;
      lvds_fmt_reg   <= `DLB_RST_LVDS_FMT;
      err_reg        <= `DLB_RST_ERROR_FLAGS;
      running_reg    <= 1'b0;
      hs_seen_reg    <= 1'b0;
      reg_rdata_reg  <= 8'h00;
      reg_rvalid_reg <= 1'b0;
    end else begin
      err_reg        <= err_next;
      reg_rvalid_reg <= reg_rd;
      if (reg_rd) begin
        reg_rdata_reg <= rd_next;
      end
      if (hs_s2_reg) begin
        hs_seen_reg <= 1'b1;
      end
      if (wr_ok) begin
        case (reg_addr)
          `DLB_OFS_PLL_CTRL: pll_ctrl_reg <= reg_wdata;
          `DLB_OFS_LANE_CFG: lane_cfg_reg <= reg_wdata;
          `DLB_OFS_LVDS_FMT: lvds_fmt_reg <= reg_wdata;
          `DLB_OFS_SOFT_RESET: begin
            if (reg_wdata[`DLB_BIT_SOFT_RESET]) begin
              running_reg <= pll_ctrl_reg[`DLB_BIT_PLL_EN];
            end
          end
          default: begin
          end
        endcase
      end
      if (wr_ok && reg_addr == `DLB_OFS_PLL_CTRL && !reg_wdata[`DLB_BIT_PLL_EN]) begin
        running_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel assembly and link output
  // ----------------------------------------------------------------
  assign single_link = lvds_fmt_reg[`DLB_BIT_SINGLE_LINK];
  assign fa_new  = dlb_fmt(pix_new, lvds_fmt_reg[`DLB_BIT_A_LSB_LANE3],
                           lvds_fmt_reg[`DLB_BIT_A_WIDE]);
  assign fa_held = dlb_fmt(pix_a_reg, lvds_fmt_reg[`DLB_BIT_A_LSB_LANE3],
                           lvds_fmt_reg[`DLB_BIT_A_WIDE]);
  assign fb_new  = dlb_fmt(pix_new, lvds_fmt_reg[`DLB_BIT_B_LSB_LANE3], 1'b1);

  always @(posedge clk_sys) begin
    if (shut) begin
      byte_cnt_reg             <= 2'h0;
      pix_part_reg             <= 16'h0000;
      pair_half_reg            <= 1'b0;
      pix_a_reg                <= 24'h000000;
      hs_d_reg                 <= 1'b0;
      a_pairs_reg              <= 18'h00000;
      a_fourth_output_pair_reg <= 6'h00;
      b_pairs_reg              <= 18'h00000;
      b_fourth_output_pair_reg <= 6'h00;
      a_clk_run_reg            <= 1'b0;
      b_clk_run_reg            <= 1'b0;
      hsync_out_reg            <= 1'b0;
      vsync_out_reg            <= 1'b0;
      de_out_reg               <= 1'b0;
      pix_strobe_reg           <= 1'b0;
    end else begin
      hs_d_reg       <= hs_s2_reg;
      hsync_out_reg  <= hsync_in;
      vsync_out_reg  <= vsync_in;
      a_clk_run_reg  <= running_reg;
      b_clk_run_reg  <= running_reg & ~single_link;
      de_out_reg     <= running_reg & hs_s2_reg;
      pix_strobe_reg <= 1'b0;
      if (m_valid) begin
        pix_part_reg <= {pix_part_reg[7:0], m_byte};
        byte_cnt_reg <= pix_done ? 2'h0 : byte_cnt_reg + 2'h1;
      end
      if (pix_done && single_link) begin
        a_pairs_reg              <= fa_new[17:0];
        a_fourth_output_pair_reg <= fa_new[23:18];
        b_pairs_reg              <= 18'h00000;
        b_fourth_output_pair_reg <= 6'h00;
        pix_strobe_reg           <= 1'b1;
      end else if (pix_done && !pair_half_reg) begin
        pix_a_reg     <= pix_new;
        pair_half_reg <= 1'b1;
      end else if (pix_done) begin
        a_pairs_reg              <= fa_held[17:0];
        a_fourth_output_pair_reg <= fa_held[23:18];
        b_pairs_reg              <= fb_new[17:0];
        b_fourth_output_pair_reg <= fb_new[23:18];
        pair_half_reg            <= 1'b0;
        pix_strobe_reg           <= 1'b1;
      end else if (!hs_s2_reg && !m_busy && !m_valid) begin
        // Idle link: drop leftovers and send black
        byte_cnt_reg             <= 2'h0;
        pair_half_reg            <= 1'b0;
        a_pairs_reg              <= 18'h00000;
        a_fourth_output_pair_reg <= 6'h00;
        b_pairs_reg              <= 18'h00000;
        b_fourth_output_pair_reg <= 6'h00;
      end
    end
  end

endmodule

// ---- testbench/dlb_bridge_core_properties.sv ----
// Port-level assertions for the bridge core
module dlb_core_props (
  // Clock, reset, enable
  input logic        clk_sys,
  input logic        reset,
  input logic        en_pin,
  // Driven inputs
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [7:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic        hsync_in,
  input logic        vsync_in,
  // Design outputs
  input logic [7:0]  reg_rdata_reg,
  input logic        reg_rvalid_reg,
  input logic [17:0] a_pairs_reg,
  input logic [5:0]  a_fourth_output_pair_reg,
  input logic        a_clk_run_reg,
  input logic [17:0] b_pairs_reg,
  input logic [5:0]  b_fourth_output_pair_reg,
  input logic        b_clk_run_reg,
  input logic        hsync_out_reg,
  input logic        vsync_out_reg,
  input logic        de_out_reg,
  input logic        pix_strobe_reg,
  input logic        out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_clr;
    reg_wr && reg_addr == 8'hE5 && reg_wdata == 8'hFF && out_oe;
  endsequence
  sequence s_rd_err;
    reg_rd && !reg_wr && reg_addr == 8'hE5;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Two sync flops plus margin
  AST_SHUT_OE: assert property (!en_pin [*4] |-> !out_oe)
    else $error("outputs enabled while enable low");
  AST_SHUT_QUIET: assert property (!out_oe [*2] |-> !pix_strobe_reg && !a_clk_run_reg
    && {a_pairs_reg, a_fourth_output_pair_reg, b_pairs_reg, b_fourth_output_pair_reg} == 48'h0)
    else $error("outputs active during shutdown");
  AST_RVALID: assert property (reg_rd && out_oe |=> reg_rvalid_reg)
    else $error("read not answered");
  AST_RVALID_CAUSE: assert property (reg_rvalid_reg |-> $past(reg_rd))
    else $error("read answer without request");
  AST_ERR_CLEAR: assert property (s_clr ##2 s_rd_err |=> reg_rdata_reg == 8'h00)
    else $error("error flags not cleared");
  AST_IDLE_ZERO: assert property (!de_out_reg [*8] |->
    {a_pairs_reg, a_fourth_output_pair_reg, b_pairs_reg, b_fourth_output_pair_reg} == 48'h0)
    else $error("pixel data not zero while idle");
  AST_SYNC_PASS: assert property (out_oe [*3] |-> hsync_out_reg == $past(hsync_in)
    && vsync_out_reg == $past(vsync_in))
    else $error("sync state not conveyed");
  AST_B_QUIET: assert property (!b_clk_run_reg |->
    b_pairs_reg == 18'h0 && b_fourth_output_pair_reg == 6'h0)
    else $error("channel b active while stopped");
  AST_STROBE_GAP: assert property (pix_strobe_reg |=> !pix_strobe_reg [*2])
    else $error("pixel strobes closer than three bytes");
  AST_STROBE_RUN: assert property (pix_strobe_reg |-> a_clk_run_reg)
    else $error("pixel output while not running");
endmodule
bind dlb_bridge_core dlb_core_props i_props (.*);

// ---- testbench/dlb_dsi_host_model.sv ----
// Behavioural DSI host: byte clock, burst flag and lane bytes
module dlb_dsi_host_model #(
  parameter int LANES = 4
) (
  // Link toward the bridge
  output logic               byte_clk,
  output logic               lane_hs,
  output logic [8*LANES-1:0] lane_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: clock still, data lanes in low power
  initial begin
    byte_clk = 1'b0;
    lane_hs = 1'b0;
    lane_bytes = '1;
  end
  // One burst; odd offset keeps the link out of phase with the core clock
  task automatic burst(input int cnt, input logic [7:0] q[$]);
    int n;
    n = 0;
    #201;
    lane_hs = 1'b1;
    while (n < q.size()) begin
      // All lanes change together, so they stay aligned
      for (int k = 0; k < LANES; k++) begin
        lane_bytes[8*k +: 8] = (k < cnt && n + k < q.size()) ? q[n+k] : 8'hFF;
      end
      byte_clk = 1'b1;
      #40;
      byte_clk = 1'b0;
      #40;
      n += cnt;
    end
    // Back to LP11 on every lane, not a copy of the last word
    lane_hs = 1'b0;
    lane_bytes = '1;
    #200;
  endtask
endmodule

// ---- testbench/tb_dlb_bridge_core.sv ----
// Self-checking bench for the bridge core
module tb_dlb_bridge_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RA [4] = '{8'h0D, 8'h10, 8'h18, 8'hE5};
  localparam logic [7:0] RV [4] = '{8'h00, 8'h03, 8'h00, 8'h00};
  localparam logic [7:0] CFG [5] = '{8'h18, 8'h1A, 8'h12, 8'h0B, 8'h09};
  localparam logic [1:0] LM1 [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  localparam logic [23:0] PIX [4] = '{24'hE1B42D, 24'h3C5A69, 24'h8F07D2, 24'h51C3B6};
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        en_pin = 1'b0;
  logic        hsync_in = 1'b0;
  logic        vsync_in = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  rdv;
  logic [47:0] got[$];
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;
  wire         dsi_byte_clk, dsi_lane_hs, reg_rvalid_reg, a_clk_run_reg, b_clk_run_reg;
  wire         hsync_out_reg, vsync_out_reg, de_out_reg, pix_strobe_reg, out_oe;
  wire [31:0]  dsi_lane_bytes;
  wire [7:0]   reg_rdata_reg;
  wire [17:0]  a_pairs_reg, b_pairs_reg;
  wire [5:0]   a_fourth_output_pair_reg, b_fourth_output_pair_reg;
  dlb_bridge_core #(.LANES(4)) i_dut (.*);
  dlb_dsi_host_model #(.LANES(4)) i_host (.byte_clk(dsi_byte_clk), .lane_hs(dsi_lane_hs),
    .lane_bytes(dsi_lane_bytes));
  always #2 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sampled mid-cycle, where the registered outputs have settled
  always @(negedge clk_sys) begin
    cycles++;
    if (pix_strobe_reg === 1'b1)
      got.push_back({a_pairs_reg, a_fourth_output_pair_reg, b_pairs_reg, b_fourth_output_pair_reg});
    if (cycles == 10000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [23:0] fmt(input logic [23:0] p, input logic lsb, input logic wide);
    if (lsb)
      fmt = {p[23:18], p[15:10], p[7:2], wide ? {p[17:16], p[9:8], p[1:0]} : 6'h00};
    else
      fmt = {p[21:16], p[13:8], p[5:0], p[23:22], p[15:14], p[7:6]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    for (int i = 0; i < 4 && reg_rvalid_reg !== 1'b1; i++) @(negedge clk_sys);
    chk("rvalid", reg_rvalid_reg, 1'b1);
    rdv = reg_rdata_reg;
  endtask
  // Pixels go out R, G, B; tail settles before the next check
  task automatic send(input int cnt, input int nb);
    logic [7:0] q[$];
    got.delete();
    for (int i = 0; i < nb; i++) q.push_back(8'(PIX[i/3] >> (8 * (2 - i % 3))));
    i_host.burst(cnt, q);
    repeat (20) @(negedge clk_sys);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_shut();
    chk("oe_shut", out_oe, 1'b0);
    wr(8'h18, 8'hFF);
    en_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("oe_on", out_oe, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(RA[i]);
      chk("reset_val", rdv, RV[i]);
    end
  endtask
  task automatic t_unready();
    send(4, 6);
    chk("strobes_idle", got.size(), 0);
    rd(8'hE5);
    chk("err_not_run", rdv[1], 1'b1);
    wr(8'hE5, 8'hFF);
    rd(8'hE5);
    chk("err_clear", rdv, 8'h00);
    rd(8'h77);
    chk("unmapped", rdv, 8'h00);
  endtask
  task automatic t_init();
    wr(8'h0D, 8'h01);
    wr(8'h09, 8'h01);
    rd(8'h0A);
    chk("running", rdv[0], 1'b1);
    chk("hs_seen", rdv[1], 1'b1);
    rd(8'h0D);
    chk("readback", rdv, 8'h01);
    hsync_in = 1'b1;
    vsync_in = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("sync", {hsync_out_reg, vsync_out_reg, a_pairs_reg}, {2'b11, 18'h0});
    hsync_in = 1'b0;
    vsync_in = 1'b0;
  endtask
  task automatic t_fmt(input logic [7:0] cfg, input logic [1:0] lm1);
    logic [47:0] e;
    int np;
    wr(8'h10, {6'h00, lm1});
    wr(8'h18, cfg);
    send(int'(lm1) + 1, 12);
    np = cfg[4] ? 4 : 2;
    chk("strobes", got.size(), np);
    for (int k = 0; k < np && k < got.size(); k++) begin
      if (cfg[4])
        e = {fmt(PIX[k], cfg[1], cfg[3]), 24'h0};
      else
        e = {fmt(PIX[2*k], cfg[1], cfg[3]), fmt(PIX[2*k+1], cfg[0], 1'b1)};
      chk("pixel", got[k], e);
    end
    chk("idle_zero", {a_pairs_reg, b_pairs_reg}, 36'h0);
    chk("de_idle", de_out_reg, 1'b0);
    chk("clk_run", {a_clk_run_reg, b_clk_run_reg}, {1'b1, ~cfg[4]});
    rd(8'hE5);
    chk("no_err", rdv, 8'h00);
  endtask
  task automatic t_err();
    wr(8'h10, 8'h02);
    wr(8'h18, 8'h08);
    send(3, 3);
    rd(8'hE5);
    chk("err_unpaired", rdv[2], 1'b1);
    wr(8'h10, 8'h03);
    wr(8'h18, 8'h18);
    wr(8'hE5, 8'hFF);
    send(4, 4);
    rd(8'hE5);
    chk("err_partial", rdv, 8'h01);
  endtask
  // Nonzero flags: back to the lane-state step through the enable pin
  task automatic t_restart();
    en_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("oe_restart", out_oe, 1'b0);
    en_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd(8'hE5);
    chk("err_restart", rdv, 8'h00);
    rd(8'h0A);
    chk("idle_restart", rdv[0], 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    t_shut();
    t_unready();
    t_init();
    for (int i = 0; i < 5; i++) t_fmt(CFG[i], LM1[i]);
    t_err();
    t_restart();
    summarize();
  end
endmodule
